// *** pkg/uart_regs.vh ***
/*
  Register indices, field positions, reset values and rate constants for
  one enhanced serial channel. Assumes byte address = 4 * index on a
  32-bit AXI4-Lite bus; every register sits in the low bits of its word.
*/
`ifndef UART_REGS_VH
`define UART_REGS_VH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_TIMER2_CONTROL 11'h418
`define IDX_TIMER2_MODE_CONTROL 11'h419
`define IDX_SYSTEM_CONFIGURATION 11'h440
`define IDX_SERIAL_CONTROL 11'h420
`define IDX_DATA_BUFFER 11'h421
`define IDX_EXT_STATUS 11'h422
`define IDX_TIMER1_RELOAD 11'h423
`define IDX_TIMER2_RELOAD 11'h424

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define T2_RX_SEL_BIT 5
`define T2_TX_SEL_BIT 4
`define PRESCALE_SEL_HI_BIT 3
`define PRESCALE_SEL_LO_BIT 2
`define CTRL_MODE_HI 7
`define CTRL_MODE_LO 6
`define CTRL_RX_ENABLE 4
`define CTRL_TX_NINTH 3
`define CTRL_RX_NINTH 2
`define CTRL_TX_DONE 1
`define CTRL_RX_DONE 0
`define STAT_FRAMING 3
`define STAT_BREAK 2
`define STAT_OVERRUN 1
`define STAT_IRQ_ENABLE 0
`define T1_EIGHT_BIT_POS 16

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_REG8 8'h00
`define RST_RELOAD 16'h0000
`define RST_T1_EIGHT_BIT 1'b1

// ----------------------------------------------------------------------
// Rate constants
// ----------------------------------------------------------------------
`define PRE_TERM_DIV4 6'h03
`define PRE_TERM_DIV16 6'h0f
`define PRE_TERM_DIV64 6'h3f
`define SUBS_LAST 4'hf
`define SUB_SAMPLE 4'h7
`define LAST_IDX_SHIFT 4'h7
`define LAST_IDX_EIGHT 4'h9
`define LAST_IDX_NINE 4'ha
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// *** src/rate_timer.v ***
/*
  Reload counter used as a rate generator. Counts one step per prescaled
  pulse and gives a one-cycle overflow pulse. Assumes step is a one-cycle
  pulse in the aclk domain.
*/
module rate_timer (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Control
  input wire step,
  input wire eight_bit,
  input wire [15:0] reload,
  // Result
  output reg overflow
);

  reg [15:0] count;
  reg [16:0] last_cfg;
  wire top = eight_bit ? (count[7:0] == 8'hff) : (count == 16'hffff);
  wire cfg_new = {eight_bit, reload} != last_cfg;

  // --------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count <= 16'h0000;
      last_cfg <= 17'h00000;
      overflow <= 1'b0;
    end
    else
    begin
      overflow <= step & top;
      last_cfg <= {eight_bit, reload};
      if (cfg_new)
        count <= reload;
      else if (step)
      begin
        if (top && eight_bit)
          count <= {count[15:8], reload[7:0]}; // [R11]
        else if (top)
          count <= reload; // [R11]
        else if (eight_bit)
          count <= {count[15:8], count[7:0] + 8'h01};
        else
          count <= count + 16'h0001;
      end
    end
  end

endmodule

// *** src/uart_channel.v ***
/*
  One enhanced serial channel: double-buffered transmitter, receiver with
  extended status, rate generation and an AXI4-Lite register slave.
  Assumes all inputs are synchronous to aclk and one bus master.
*/
// Design decision made here: register access over AXI4-Lite.
`include "uart_regs.vh"

// Behaviour
// [R1] Done flag sets at end of each byte
// [R2] Done flag sets on idle buffer write
// [R3] Buffered byte follows stop bit without gap
// [R4] Ninth transmit bit is read live
// [R5] Host clears done flag for single buffering
// [R6] Sampling clock is sixteen times bit rate
// [R7] Fixed rates are oscillator/16 and oscillator/32
// [R8] Variable rate is timer overflow over sixteen
// [R9] Variable rate at most oscillator over 64
// [R10] Prescaler codes divide 4, 16, 64; reserved
// [R11] Timer range 256 or 65536
// [R12] Timer 2 steps at prescaled oscillator rate
// [R13] Timer 2 select bits route each direction
// [R14] Missing stop bit sets sticky framing flag
// [R15] All-zero character sets sticky break flag
// [R16] Bit eight with receive flag sets overrun
// [R17] Status enable forwards errors to receive request
// [R18] Data buffer writes transmit, reads receive
// [R19] Eight-bit frame: start, eight data, stop
// [R20] Nine-bit frame adds programmable ninth bit
module uart_channel (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write channels
  input wire [12:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read channels
  input wire [12:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Serial pins
  input wire serial_in_pin,
  output reg serial_in_pin_out,
  output reg serial_in_pin_oe,
  output reg serial_out_pin,
  // Interrupt requests
  output reg rx_irq_req,
  output reg tx_irq_req
);

  reg aw_got, w_got;
  reg [10:0] waddr;
  reg [31:0] wdata;
  reg [3:0] wstrb;
  reg [7:0] timer2_control, timer2_mode_control, system_configuration;
  reg [1:0] mode;
  reg rx_enable, tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag;
  reg framing_err_flag, line_break_flag, overrun_flag, status_irq_enable;
  reg [15:0] t1_reload, t2_reload;
  reg t1_eight_bit;
  reg [5:0] pre_cnt;
  reg timer_prescaled_clock, fix_phase;
  reg tx_busy, tx_buf_full;
  reg [7:0] tx_data, tx_buf;
  reg [3:0] tx_idx, tx_sub;
  reg rx_busy, rx_prev, rx_zero, rx_n9;
  reg [7:0] rx_shift, rx_data;
  reg [3:0] rx_idx, rx_sub;
  reg [31:0] rd_mux;
  reg rd_hit, tx_bit;
  wire t1_ovf, t2_ovf;

  // --------------------------------------------------------------------
  // Bus handshakes
  // --------------------------------------------------------------------
  wire do_write = aw_got & w_got & ~s_axi_bvalid;
  wire next_aw_got = do_write ? 1'b0 : (aw_got | (s_axi_awvalid & s_axi_awready));
  wire next_w_got = do_write ? 1'b0 : (w_got | (s_axi_wvalid & s_axi_wready));
  wire rd_take = s_axi_arvalid & s_axi_arready;
  wire next_rvalid = (s_axi_rvalid & ~s_axi_rready) | rd_take;
  wire wr_lane0 = do_write & wstrb[0];
  wire wr_t2c = wr_lane0 & (waddr == `IDX_TIMER2_CONTROL);
  wire wr_t2m = wr_lane0 & (waddr == `IDX_TIMER2_MODE_CONTROL);
  wire wr_scr = wr_lane0 & (waddr == `IDX_SYSTEM_CONFIGURATION);
  wire wr_ctl = wr_lane0 & (waddr == `IDX_SERIAL_CONTROL);
  wire wr_buf = wr_lane0 & (waddr == `IDX_DATA_BUFFER);
  wire wr_sta = wr_lane0 & (waddr == `IDX_EXT_STATUS);
  wire wr_t1 = do_write & (waddr == `IDX_TIMER1_RELOAD);
  wire wr_t2 = do_write & (waddr == `IDX_TIMER2_RELOAD);
  wire wr_hit = (waddr == `IDX_TIMER2_CONTROL) |
    (waddr == `IDX_TIMER2_MODE_CONTROL) |
    (waddr == `IDX_SYSTEM_CONFIGURATION) |
    (waddr == `IDX_SERIAL_CONTROL) | (waddr == `IDX_DATA_BUFFER) |
    (waddr == `IDX_EXT_STATUS) | (waddr == `IDX_TIMER1_RELOAD) |
    (waddr == `IDX_TIMER2_RELOAD);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      waddr <= 11'h000;
      wdata <= 32'h00000000;
      wstrb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else
    begin
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      s_axi_awready <= ~next_aw_got;
      s_axi_wready <= ~next_w_got;
      if (s_axi_awvalid && s_axi_awready)
        waddr <= s_axi_awaddr[12:2];
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata <= s_axi_wdata;
        wstrb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      s_axi_rvalid <= next_rvalid;
      s_axi_arready <= ~next_rvalid;
      if (rd_take)
      begin
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // --------------------------------------------------------------------
  // Read decode
  // --------------------------------------------------------------------
  always @*
  begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case (s_axi_araddr[12:2])
      `IDX_TIMER2_CONTROL: rd_mux[7:0] = timer2_control;
      `IDX_TIMER2_MODE_CONTROL: rd_mux[7:0] = timer2_mode_control;
      `IDX_SYSTEM_CONFIGURATION: rd_mux[7:0] = system_configuration;
      `IDX_SERIAL_CONTROL: rd_mux[7:0] = {mode, 1'b0, rx_enable,
        tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag};
      `IDX_DATA_BUFFER: rd_mux[7:0] = rx_data; // [R18]
      `IDX_EXT_STATUS: rd_mux[7:0] = {4'h0, framing_err_flag,
        line_break_flag, overrun_flag, status_irq_enable};
      `IDX_TIMER1_RELOAD: rd_mux[16:0] = {t1_eight_bit, t1_reload};
      `IDX_TIMER2_RELOAD: rd_mux[15:0] = t2_reload;
      default: rd_hit = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------
  // Rate generation
  // --------------------------------------------------------------------
  wire [1:0] pre_sel = {system_configuration[`PRESCALE_SEL_HI_BIT],
    system_configuration[`PRESCALE_SEL_LO_BIT]};
  wire [5:0] pre_term = (pre_sel == 2'b00) ? `PRE_TERM_DIV4 : // [R10]
    (pre_sel == 2'b01) ? `PRE_TERM_DIV16 : `PRE_TERM_DIV64; // [R10]
  wire pre_hit = (pre_cnt == pre_term) & (pre_sel != 2'b11); // [R10]

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pre_cnt <= 6'h00;
      timer_prescaled_clock <= 1'b0;
      fix_phase <= 1'b0;
    end
    else
    begin
      pre_cnt <= (pre_hit || pre_sel == 2'b11) ? 6'h00 : pre_cnt + 6'h01;
      timer_prescaled_clock <= pre_hit; // [R9]
      fix_phase <= ~fix_phase;
    end
  end

  rate_timer u_timer1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .step(timer_prescaled_clock),
    .eight_bit(t1_eight_bit),
    .reload(t1_reload),
    .overflow(t1_ovf)
  );

  rate_timer u_timer2 (
    .aclk(aclk),
    .aresetn(aresetn),
    .step(timer_prescaled_clock), // [R12]
    .eight_bit(1'b0),
    .reload(t2_reload),
    .overflow(t2_ovf)
  );

  // Each tick is one sixteenth of a bit.
  wire t2_tx = timer2_control[`T2_TX_SEL_BIT];
  wire t2_rx = timer2_control[`T2_RX_SEL_BIT];
  wire var_tx = t2_tx ? t2_ovf : t1_ovf; // [R13]
  wire var_rx = t2_rx ? t2_ovf : t1_ovf; // [R13]
  wire fixed_tick = (mode == 2'b00) | fix_phase; // [R7]
  wire tx_tick = mode[0] ? var_tx : fixed_tick; // [R6] [R8]
  wire rx_tick = mode[0] ? var_rx : fixed_tick; // [R6] [R8]
  wire [3:0] last_idx = (mode == 2'b00) ? `LAST_IDX_SHIFT :
    (mode == 2'b01) ? `LAST_IDX_EIGHT : `LAST_IDX_NINE; // [R19] [R20]

  // --------------------------------------------------------------------
  // Transmitter
  // --------------------------------------------------------------------
  wire tx_end = tx_busy & tx_tick & (tx_sub == `SUBS_LAST) &
    (tx_idx == last_idx);
  wire tx_step = tx_busy & tx_tick & ~tx_end;
  wire [3:0] tx_im1 = tx_idx - 4'h1;
  wire tx_start_idle = wr_buf & ~tx_busy;

  always @*
  begin
    if (mode == 2'b00)
      tx_bit = tx_data[tx_idx[2:0]];
    else if (tx_idx == 4'h0)
      tx_bit = 1'b0;
    else if (tx_idx <= 4'h8)
      tx_bit = tx_data[tx_im1[2:0]]; // [R19]
    else if (tx_idx == 4'h9 && mode[1])
      tx_bit = tx_ninth_bit; // [R4] [R20]
    else
      tx_bit = 1'b1;
  end

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_busy <= 1'b0;
      tx_buf_full <= 1'b0;
      tx_data <= 8'h00;
      tx_buf <= 8'h00;
      tx_idx <= 4'h0;
      tx_sub <= 4'h0;
      serial_out_pin <= 1'b1;
      serial_in_pin_out <= 1'b1;
      serial_in_pin_oe <= 1'b0;
    end
    else
    begin
      if (tx_step)
      begin
        tx_sub <= tx_sub + 4'h1;
        if (tx_sub == `SUBS_LAST)
          tx_idx <= tx_idx + 4'h1;
      end
      if (tx_end)
      begin
        tx_idx <= 4'h0;
        tx_sub <= 4'h0;
        if (tx_buf_full)
        begin
          tx_data <= tx_buf; // [R3]
          tx_buf_full <= 1'b0;
        end
        else if (wr_buf)
          tx_data <= wdata[7:0]; // [R3]
        else
          tx_busy <= 1'b0;
      end
      else if (wr_buf && tx_busy && !tx_buf_full)
      begin
        tx_buf <= wdata[7:0];
        tx_buf_full <= 1'b1;
      end
      if (tx_start_idle)
      begin
        tx_busy <= 1'b1;
        tx_data <= wdata[7:0]; // [R18]
        tx_idx <= 4'h0;
        tx_sub <= 4'h0;
      end
      if (mode == 2'b00)
      begin
        serial_out_pin <= ~tx_busy | tx_sub[3];
        serial_in_pin_out <= tx_busy ? tx_bit : 1'b1;
        serial_in_pin_oe <= tx_busy;
      end
      else
      begin
        serial_out_pin <= tx_busy ? tx_bit : 1'b1;
        serial_in_pin_out <= 1'b1;
        serial_in_pin_oe <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Receiver
  // --------------------------------------------------------------------
  wire rx_sample = rx_busy & rx_tick & (rx_sub == `SUB_SAMPLE);
  wire rx_last = rx_sample & (rx_idx == last_idx);
  wire rx_false = rx_sample & (rx_idx == 4'h0) & serial_in_pin;
  wire rx_begin = ~rx_busy & rx_enable & (mode != 2'b00) & rx_prev &
    ~serial_in_pin;
  wire set_fe = rx_last & ~serial_in_pin; // [R14]
  wire set_br = rx_last & rx_zero & ~serial_in_pin; // [R15]
  wire set_oe = rx_sample & (rx_idx == 4'h8) & rx_done_flag; // [R16]

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_busy <= 1'b0;
      rx_prev <= 1'b1;
      rx_zero <= 1'b0;
      rx_n9 <= 1'b0;
      rx_shift <= 8'h00;
      rx_data <= 8'h00;
      rx_idx <= 4'h0;
      rx_sub <= 4'h0;
    end
    else
    begin
      rx_prev <= serial_in_pin;
      if (rx_begin)
      begin
        rx_busy <= 1'b1;
        rx_zero <= 1'b1;
        rx_idx <= 4'h0;
        rx_sub <= 4'h0;
      end
      else if (rx_busy && rx_tick)
      begin
        rx_sub <= rx_sub + 4'h1;
        if (rx_sub == `SUBS_LAST)
          rx_idx <= rx_idx + 4'h1;
      end
      if (rx_sample)
      begin
        if (serial_in_pin)
          rx_zero <= 1'b0;
        if (rx_idx >= 4'h1 && rx_idx <= 4'h8)
          rx_shift <= {serial_in_pin, rx_shift[7:1]}; // [R19]
        if (rx_idx == 4'h9)
          rx_n9 <= serial_in_pin; // [R20]
      end
      if (rx_false || rx_last)
        rx_busy <= 1'b0;
      if (rx_last)
        rx_data <= rx_shift;
    end
  end

  // --------------------------------------------------------------------
  // Software registers and flags
  // --------------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer2_control <= `RST_REG8;
      timer2_mode_control <= `RST_REG8;
      system_configuration <= `RST_REG8;
      mode <= 2'b00;
      rx_enable <= 1'b0;
      tx_ninth_bit <= 1'b0;
      rx_ninth_bit <= 1'b0;
      tx_done_flag <= 1'b0;
      rx_done_flag <= 1'b0;
      framing_err_flag <= 1'b0;
      line_break_flag <= 1'b0;
      overrun_flag <= 1'b0;
      status_irq_enable <= 1'b0;
      t1_reload <= `RST_RELOAD;
      t2_reload <= `RST_RELOAD;
      t1_eight_bit <= `RST_T1_EIGHT_BIT;
      rx_irq_req <= 1'b0;
      tx_irq_req <= 1'b0;
    end
    else
    begin
      if (wr_t2c)
        timer2_control <= wdata[7:0];
      if (wr_t2m)
        timer2_mode_control <= wdata[7:0];
      if (wr_scr)
        system_configuration <= wdata[7:0];
      if (wr_ctl)
      begin
        mode <= wdata[`CTRL_MODE_HI:`CTRL_MODE_LO];
        rx_enable <= wdata[`CTRL_RX_ENABLE];
        tx_ninth_bit <= wdata[`CTRL_TX_NINTH];
      end
      if (rx_last)
        rx_ninth_bit <= mode[1] ? rx_n9 : serial_in_pin;
      else if (wr_ctl)
        rx_ninth_bit <= wdata[`CTRL_RX_NINTH];
      tx_done_flag <= tx_end | tx_start_idle | // [R1] [R2]
        (wr_ctl ? wdata[`CTRL_TX_DONE] : tx_done_flag); // [R5]
      rx_done_flag <= rx_last |
        (wr_ctl ? wdata[`CTRL_RX_DONE] : rx_done_flag);
      framing_err_flag <= set_fe | (framing_err_flag &
        ~(wr_sta & ~wdata[`STAT_FRAMING])); // [R14]
      line_break_flag <= set_br | (line_break_flag &
        ~(wr_sta & ~wdata[`STAT_BREAK])); // [R15]
      overrun_flag <= set_oe | (overrun_flag &
        ~(wr_sta & ~wdata[`STAT_OVERRUN])); // [R16]
      if (wr_sta)
        status_irq_enable <= wdata[`STAT_IRQ_ENABLE];
      if (wr_t1 && wstrb[0])
        t1_reload[7:0] <= wdata[7:0];
      if (wr_t1 && wstrb[1])
        t1_reload[15:8] <= wdata[15:8];
      if (wr_t1 && wstrb[2])
        t1_eight_bit <= wdata[`T1_EIGHT_BIT_POS];
      if (wr_t2 && wstrb[0])
        t2_reload[7:0] <= wdata[7:0];
      if (wr_t2 && wstrb[1])
        t2_reload[15:8] <= wdata[15:8];
      rx_irq_req <= rx_done_flag | (status_irq_enable &
        (framing_err_flag | line_break_flag | overrun_flag)); // [R17]
      tx_irq_req <= tx_done_flag;
    end
  end

endmodule

// *** bench/uart_channel_checker.sv ***
/*
  Concurrent checks on the bus handshakes and serial line of one channel.
  Assumes it is bound to uart_channel and sees only its ports.
*/
module uart_channel_checker (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Bus handshakes
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Serial pins
  input wire serial_out_pin,
  input wire serial_in_pin_out,
  input wire serial_in_pin_oe
);
  // --------------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  reset_idle_a: assert property (
    $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && serial_out_pin)
    else $error("outputs not idle after reset");
  write_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
  aw_refuse_a: assert property (
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("write address accepted twice");
  bvalid_drop_a: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response late");
  rvalid_drop_a: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated");
  low_width_a: assert property (
    $fell(serial_out_pin) |=> !serial_out_pin [*7])
    else $error("low level too short");
  high_width_a: assert property (
    $rose(serial_out_pin) |=> serial_out_pin [*7])
    else $error("high level too short");
  pin_release_a: assert property (
    !serial_in_pin_oe |-> serial_in_pin_out)
    else $error("pin low while released");
endmodule

bind uart_channel uart_channel_checker uart_channel_checker_inst (.*);

// *** bench/serial_partner.sv ***
/*
  Remote serial device: sends frames on the receive line and samples
  frames from the transmit line. Assumes it shares the channel's clock.
*/
module serial_partner (
  // Clock
  input wire aclk,
  // Serial lines
  input wire serial_out_pin,
  output logic line_drive
);
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------------
  // Frame tasks
  // --------------------------------------------------------------------
  initial line_drive = 1'b1;

  // Bit 0 of the frame goes first; the line idles high afterwards.
  task automatic send(input logic [10:0] frame, input int nbits,
    input int bitlen);
    for (int i = 0; i < nbits; i++)
    begin
      line_drive <= frame[i];
      repeat (bitlen) @(posedge aclk);
    end
    line_drive <= 1'b1;
    repeat (bitlen) @(posedge aclk);
  endtask

  // Waits for a start bit, then samples each bit at its middle.
  task automatic capture(input int nbits, input int bitlen,
    output logic [10:0] frame, output int gap);
    gap = 0;
    frame = '0;
    while (serial_out_pin !== 1'b0)
    begin
      @(posedge aclk);
      gap++;
    end
    repeat (bitlen / 2) @(posedge aclk);
    for (int i = 0; i < nbits; i++)
    begin
      frame[i] = serial_out_pin;
      if (i < nbits - 1)
        repeat (bitlen) @(posedge aclk);
    end
  endtask
endmodule

// *** bench/test_uart_channel.sv ***
/*
  Self-checking bench for one serial channel: registers, transmit rates
  and framing, buffering and receive status. Assumes serial_partner.
*/
`include "uart_regs.vh"
module test_uart_channel;
  timeunit 1ns;
  timeprecision 1ps;
  // --------------------------------------------------------------------
  // Signals and instances
  // --------------------------------------------------------------------
  localparam logic [12:0] a_ctrl = {`IDX_SERIAL_CONTROL, 2'b00};
  localparam logic [12:0] a_data = {`IDX_DATA_BUFFER, 2'b00};
  localparam logic [12:0] a_stat = {`IDX_EXT_STATUS, 2'b00};
  localparam logic [12:0] a_t1 = {`IDX_TIMER1_RELOAD, 2'b00};
  localparam logic [12:0] a_t2 = {`IDX_TIMER2_RELOAD, 2'b00};
  localparam logic [12:0] a_t2c = {`IDX_TIMER2_CONTROL, 2'b00};
  localparam logic [12:0] a_sys = {`IDX_SYSTEM_CONFIGURATION, 2'b00};
  logic aclk = 0;
  logic aresetn = 0;
  logic [12:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, line_drive;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic serial_in_pin_out, serial_in_pin_oe, serial_out_pin;
  logic rx_irq_req, tx_irq_req;
  logic [10:0] fr;
  int gap, fails = 0, samples_checked = 0;
  wire serial_in_pin = serial_in_pin_oe ? serial_in_pin_out : line_drive;

  always #2 aclk = ~aclk;

  uart_channel uart_channel_inst (.*);
  serial_partner serial_partner_inst (.aclk(aclk),
    .serial_out_pin(serial_out_pin), .line_drive(line_drive));

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
    input logic [31:0] want);
    samples_checked++;
    if (seen !== want)
    begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, want, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic axw(input logic [12:0] a, input logic [31:0] d);
    logic aw_done, w_done;
    aw_done = 0;
    w_done = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'b1)
      begin
        aw_done = 1;
        s_axi_awvalid <= 0;
      end
      if (!w_done && s_axi_wready === 1'b1)
      begin
        w_done = 1;
        s_axi_wvalid <= 0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask

  task automatic axr(input logic [12:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 0;
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task automatic test_regs();
    logic [12:0] adr [5] = '{a_ctrl, a_stat, a_t1, a_sys, a_t2c};
    logic [31:0] val [5] = '{0, 0, 32'h10000, 0, 0};
    for (int i = 0; i < 5; i++)
    begin
      axr(adr[i]);
      check("reset value", rd, val[i]);
    end
    axr(13'h1ffc);
    check("unmapped read", resp, 2'b10);
    axw(13'h1ffc, 32'h0);
    check("unmapped write", resp, 2'b10);
    axw(a_sys, 32'h0c);
    axr(a_sys);
    check("prescale field", rd, 32'h0c);
    $display("test_regs done");
  endtask

  task automatic tx_cfg(input logic [7:0] sys, t2c, input logic [31:0] t1,
    t2, input logic [7:0] ctrl, input int bitlen, nbits,
    input logic [10:0] want);
    axw(a_sys, sys);
    axw(a_t2c, t2c);
    axw(a_t1, t1);
    axw(a_t2, t2);
    axw(a_ctrl, ctrl);
    fork
      serial_partner_inst.capture(nbits, bitlen, fr, gap);
      begin
        axw(a_data, want[8:1]);
        axr(a_ctrl);
        check("idle done", rd[1], 1);
        axw(a_ctrl, ctrl);
      end
    join
    check("frame", fr, want);
    repeat (bitlen) @(posedge aclk);
    axr(a_ctrl);
    check("end done", rd[1], 1);
    $display("tx_cfg done, bit length %0d", bitlen);
  endtask

  task automatic test_b2b();
    axw(a_ctrl, 32'h40);
    fork
      begin
        serial_partner_inst.capture(10, 64, fr, gap);
        check("first frame", fr, 11'h34a);
        serial_partner_inst.capture(10, 64, fr, gap);
        check("second frame", fr, 11'h278);
        check("gap", gap <= 34, 1);
      end
      begin
        axw(a_data, 32'ha5);
        axw(a_ctrl, 32'h40);
        axw(a_data, 32'h3c);
        axr(a_ctrl);
        check("busy done", rd[1], 0);
      end
    join
    repeat (64) @(posedge aclk);
    axr(a_ctrl);
    check("last done", rd[1], 1);
    $display("test_b2b done");
  endtask

  task automatic test_rx();
    axw(a_ctrl, 32'h50);
    serial_partner_inst.send({1'b1, 8'h96, 1'b0}, 10, 64);
    axr(a_ctrl);
    check("rx done", rd[0], 1);
    axr(a_data);
    check("rx buffer", rd[7:0], 8'h96);
    serial_partner_inst.send({1'b1, 8'h11, 1'b0}, 10, 64);
    axr(a_stat);
    check("overrun", rd[3:0], 4'h2);
    axw(a_ctrl, 32'h50);
    axw(a_stat, 32'h0f);
    repeat (3) @(posedge aclk);
    check("status irq", rx_irq_req, 1);
    axw(a_stat, 32'h01);
    repeat (3) @(posedge aclk);
    check("irq cleared", rx_irq_req, 0);
    serial_partner_inst.send({1'b0, 8'h55, 1'b0}, 10, 64);
    axr(a_stat);
    check("framing", rd[3:0], 4'h9);
    check("framing irq", rx_irq_req, 1);
    axw(a_stat, 32'h00);
    axw(a_ctrl, 32'h50);
    serial_partner_inst.send(11'h000, 10, 64);
    axr(a_stat);
    check("break", rd[3:0], 4'hc);
    axw(a_stat, 32'h00);
    $display("test_rx done");
  endtask

  initial
  begin
    repeat (6) @(posedge aclk);
    aresetn <= 1;
    test_regs();
    tx_cfg(8'h00, 8'h00, 32'h100ff, 0, 8'h40, 64, 10, 11'h2b4);
    test_b2b();
    test_rx();
    tx_cfg(8'h04, 8'h00, 32'h100ff, 0, 8'h40, 256, 10, 11'h3fe);
    tx_cfg(8'h08, 8'h00, 32'h100ff, 0, 8'h40, 1024, 10, 11'h202);
    tx_cfg(8'h00, 8'h00, 32'hffff, 0, 8'h40, 64, 10, 11'h2f0);
    tx_cfg(8'h00, 8'h10, 32'h100ff, 32'hfffe, 8'h40, 128, 10, 11'h20e);
    tx_cfg(8'h00, 8'h00, 32'h100ff, 0, 8'h88, 32, 11, 11'h6c2);
    results();
  end

  initial
  begin
    repeat (60000) @(posedge aclk);
    fails++;
    results();
  end
endmodule
